// ### include/sip_regs.svh
// register map, field positions, reset values and timing counts of the system integration block
`ifndef SIP_REGS_SVH
`define SIP_REGS_SVH

// ==========================================
// register byte offsets
`define SIP_OFS_IRQ_A      8'h00
`define SIP_OFS_IRQ_B      8'h04
`define SIP_OFS_IRQ_C      8'h08
`define SIP_OFS_RST_SRC    8'h0C
`define SIP_OFS_BRK_CTL    8'h10
`define SIP_OFS_CFG_ONE    8'h14
`define SIP_OFS_BRK_STAT   8'h18
`define SIP_OFS_LP_STAT    8'h1C

// ==========================================
// field positions
`define SIP_BIT_BRK_CLR_EN 0
`define SIP_BIT_WDOG_DIS   0
`define SIP_BIT_SHORT_REC  1
`define SIP_BIT_OSC_HALT   2
`define SIP_BIT_BRK_LP     1
`define SIP_BIT_RS_LVI     1
`define SIP_BIT_RS_MON     2
`define SIP_BIT_RS_BADAD   3
`define SIP_BIT_RS_BADOP   4
`define SIP_BIT_RS_WDOG    5
`define SIP_BIT_RS_PIN     6
`define SIP_BIT_RS_POR     7

// ==========================================
// reset values
`define SIP_RST_IRQ        8'h00
`define SIP_RST_RST_SRC    8'h80
`define SIP_RST_BRK_CTL    8'h00
`define SIP_RST_CFG_ONE    8'h00
`define SIP_RST_BRK_STAT   8'h00

// ==========================================
// stop recovery in quadruple-rate bus clock cycles
`define SIP_RECOV_LONG     4096
`define SIP_RECOV_SHORT    32

`endif

// ### include/sip_pkg.sv
// types shared by the system integration block
package sip_pkg;

  // low-power sequencer states, one-hot
  typedef enum logic [3:0] {
    SIP_RUN   = 4'h1,
    SIP_WAIT  = 4'h2,
    SIP_STOP  = 4'h4,
    SIP_RECOV = 4'h8
  } sip_lp_e;

  // one-cycle reset cause pulses from the reset sources on chip
  typedef struct packed {
    logic wdog;
    logic bad_op;
    logic bad_fetch;
    logic monitor;
  } sip_rst_src_s;

  // clock gate enables
  typedef struct packed {
    logic cpu;
    logic periph;
    logic bus_clock_double;
    logic bus_clock_quad;
  } sip_clk_en_s;

endpackage

// ### rtl/sip_sync.sv
// three-stage synchroniser that accepts a change once the last two stages agree
module sip_sync (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // async level in, clean level out
  input  wire logic i_async,
  output logic      o_level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_level <= 1'b0;
    end else if (s2_r == s3_r) begin
      o_level <= s3_r;
    end
  end

endmodule

// ### rtl/sip_recov_ctr.sv
// stop recovery counter, held clear while stopped and timing recovery afterwards
`include "sip_regs.svh"
module sip_recov_ctr #(
  parameter int LONG_CYC  = `SIP_RECOV_LONG,
  parameter int SHORT_CYC = `SIP_RECOV_SHORT
) (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // control
  input  wire logic i_hold,
  input  wire logic i_short,
  // one-cycle pulse when the selected delay has elapsed
  output logic      o_done
);

  localparam int W = $clog2(LONG_CYC + 1);

  logic [W-1:0] cnt_r;
  logic [W-1:0] lim;

  assign lim = i_short ? W'(SHORT_CYC - 1) : W'(LONG_CYC - 1);

  always_ff @(posedge i_mclk) begin
    if (i_rst || i_hold) begin
      cnt_r  <= '0;
      o_done <= 1'b0;
    end else if (cnt_r == lim) begin
      cnt_r  <= '0;
      o_done <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + W'(1);
      o_done <= 1'b0;
    end
  end

endmodule

// ### rtl/sip_core.sv
// system integration: interrupt status mirrors, break handling, low-power sequencing, reset causes
`include "sip_regs.svh"
// ==========================================
// Summary of operation
// - status A: sources 6..3 and 1, gaps zero
// - status B/C mirror sources 14..7, 22..15
// - status registers read-only, reset to zero
// - all reset sources equal, no arbitration
// - break forces processor to software-interrupt vector
// - break protects flags unless clear enable set
// - flag cleared in break stays cleared
// - two-step clears stay protected during break unless clear enable set
// - wait/stop clear interrupt mask, stop processor
// - wait gates processor clock, peripherals run
// - wait interrupt wakes, stacking one cycle later
// - reset or emulation break also exits wait
// - break during wait sets low-power break flag
// - watchdog enabled, runs in wait, when not disabled
// - stop clears counter, stops both system clocks
// - stop exits at once on reset, on irq/break after recovery
// - double clock keeps running when osc kept
// - recovery 4096 quad cycles, 32 when short
// - counter held clear until recovery starts
// - reset source register clears on read
// - power-on sets own flag, clears others
// - flags for power-on, pin, watchdog, bad opcode
// - flags for bad fetch, monitor, low voltage
// - break clear enable is read/write bit
module sip_core #(
  parameter int RECOV_LONG  = `SIP_RECOV_LONG,
  parameter int RECOV_SHORT = `SIP_RECOV_SHORT
) (
  // clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  // axi4-lite write address
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [7:0]            i_awaddr,
  // axi4-lite write data
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  // axi4-lite write response
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  output logic [1:0]                 o_bresp,
  // axi4-lite read address
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  input  wire logic [7:0]            i_araddr,
  // axi4-lite read data
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp,
  // pending requests from peripherals, index = source number
  input  wire logic [22:1]           i_irq_pend,
  // processor and break module
  input  wire logic                  i_wait_exec,
  input  wire logic                  i_stop_exec,
  input  wire logic                  i_brk,
  input  wire logic                  i_emul_mode,
  // reset causes
  input  wire sip_pkg::sip_rst_src_s i_rst_src,
  input  wire logic                  i_pin_rst_n,
  input  wire logic                  i_low_volt,
  // outputs to processor and clock gates
  output sip_pkg::sip_clk_en_s       o_clk_en,
  output logic                       o_clr_imask,
  output logic                       o_swi_vec,
  output logic                       o_stack_go,
  output logic                       o_flag_clr_ok,
  output logic                       o_wdog_en
);

  // ==========================================
  // declarations
  sip_pkg::sip_lp_e lp_r;
  sip_pkg::sip_lp_e lp_nxt;
  logic [22:1]      irq_r;
  logic [7:0]       rst_src_r;
  logic [7:0]       cfg_r;
  logic             brk_clr_en_r;
  logic             brk_lp_r;
  logic             brk_r;
  logic [7:0]       aw_addr_r;
  logic [7:0]       ar_addr_r;
  logic             aw_have_r;
  logic             w_have_r;
  logic [7:0]       wdat_r;
  logic             wb0_r;
  logic             do_wr;
  logic             do_rd;
  logic             wake;
  logic             recov_done;
  logic             pin_lvl;
  logic             lvi_lvl;
  logic             pin_q_r;
  logic             lvi_q_r;
  logic [1:0]       async_in;
  logic [1:0]       async_lvl;

  function automatic logic sip_mapped(input logic [7:0] a);
    sip_mapped = (a[1:0] == 2'h0) && (a <= `SIP_OFS_LP_STAT);
  endfunction

  // ==========================================
  // pin-level reset causes through synchronisers
  assign async_in = {~i_pin_rst_n, i_low_volt};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      sip_sync u_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_async (async_in[g]),
        .o_level (async_lvl[g])
      );
    end
  endgenerate

  assign pin_lvl = async_lvl[1];
  assign lvi_lvl = async_lvl[0];

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pin_q_r <= 1'b0;
      lvi_q_r <= 1'b0;
    end else begin
      pin_q_r <= pin_lvl;
      lvi_q_r <= lvi_lvl;
    end
  end

  // ==========================================
  // axi4-lite write channel
  assign do_wr = aw_have_r && w_have_r && !o_bvalid;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      wdat_r    <= 8'h00;
      wb0_r     <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_have_r <= 1'b1;
        o_awready <= 1'b0;
        aw_addr_r <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_have_r <= 1'b1;
        o_wready <= 1'b0;
        wdat_r   <= i_wdata[7:0];
        wb0_r    <= i_wstrb[0];
      end
      if (do_wr) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= sip_mapped(aw_addr_r) ? 2'h0 : 2'h3;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // ==========================================
  // software-writable control
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      brk_clr_en_r <= 1'b0;
      cfg_r        <= `SIP_RST_CFG_ONE;
    end else if (do_wr && wb0_r) begin
      if (aw_addr_r == `SIP_OFS_BRK_CTL) begin
        brk_clr_en_r <= wdat_r[`SIP_BIT_BRK_CLR_EN];
      end
      if (aw_addr_r == `SIP_OFS_CFG_ONE) begin
        cfg_r <= {5'h00, wdat_r[2:0]};
      end
    end
  end

  // ==========================================
  // axi4-lite read channel
  assign do_rd = i_arvalid && o_arready;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= 2'h0;
      ar_addr_r <= 8'h00;
    end else if (do_rd) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      ar_addr_r <= i_araddr;
      o_rresp   <= sip_mapped(i_araddr) ? 2'h0 : 2'h3;
      unique case (i_araddr)
        `SIP_OFS_IRQ_A:    o_rdata <= {24'h000000, irq_r[6:3], 1'b0, irq_r[1], 2'h0};
        `SIP_OFS_IRQ_B:    o_rdata <= {24'h000000, irq_r[14:7]};
        `SIP_OFS_IRQ_C:    o_rdata <= {24'h000000, irq_r[22:15]};
        `SIP_OFS_RST_SRC:  o_rdata <= {24'h000000, rst_src_r};
        `SIP_OFS_BRK_CTL:  o_rdata <= {31'h0000_0000, brk_clr_en_r};
        `SIP_OFS_CFG_ONE:  o_rdata <= {24'h000000, cfg_r};
        `SIP_OFS_BRK_STAT: o_rdata <= {30'h0000_0000, brk_lp_r, 1'b0};
        `SIP_OFS_LP_STAT:  o_rdata <= {28'h000_0000, lp_r};
        default:           o_rdata <= 32'h0000_0000;
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ==========================================
  // interrupt status mirrors; writes never reach them
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      irq_r <= 22'h000000;
    end else begin
      irq_r <= i_irq_pend;
    end
  end

  // ==========================================
  // reset source flags; a cause in the same cycle as a read survives
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rst_src_r <= `SIP_RST_RST_SRC;
    end else begin
      // every cause sets its own bit in parallel, no priority among them
      rst_src_r <= (do_rd && i_araddr == `SIP_OFS_RST_SRC) ? 8'h00 : rst_src_r;
      rst_src_r[`SIP_BIT_RS_PIN]   <= (pin_lvl && !pin_q_r) ||
        (!(do_rd && i_araddr == `SIP_OFS_RST_SRC) && rst_src_r[`SIP_BIT_RS_PIN]);
      rst_src_r[`SIP_BIT_RS_WDOG]  <= i_rst_src.wdog ||
        (!(do_rd && i_araddr == `SIP_OFS_RST_SRC) && rst_src_r[`SIP_BIT_RS_WDOG]);
      rst_src_r[`SIP_BIT_RS_BADOP] <= i_rst_src.bad_op ||
        (!(do_rd && i_araddr == `SIP_OFS_RST_SRC) && rst_src_r[`SIP_BIT_RS_BADOP]);
      rst_src_r[`SIP_BIT_RS_BADAD] <= i_rst_src.bad_fetch ||
        (!(do_rd && i_araddr == `SIP_OFS_RST_SRC) && rst_src_r[`SIP_BIT_RS_BADAD]);
      rst_src_r[`SIP_BIT_RS_MON]   <= i_rst_src.monitor ||
        (!(do_rd && i_araddr == `SIP_OFS_RST_SRC) && rst_src_r[`SIP_BIT_RS_MON]);
      rst_src_r[`SIP_BIT_RS_LVI]   <= (lvi_lvl && !lvi_q_r) ||
        (!(do_rd && i_araddr == `SIP_OFS_RST_SRC) && rst_src_r[`SIP_BIT_RS_LVI]);
      rst_src_r[0] <= 1'b0;
    end
  end

  // ==========================================
  // break handling
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      brk_r         <= 1'b0;
      o_swi_vec     <= 1'b0;
      o_flag_clr_ok <= 1'b1;
    end else begin
      brk_r         <= i_brk;
      o_swi_vec     <= i_brk && !brk_r;
      // peripherals gate the second clearing step on this, so unless break clear enable is set a first step taken before
      // break cannot complete inside it, and anything cleared stays cleared
      o_flag_clr_ok <= !i_brk || brk_clr_en_r;
    end
  end

  // set wins over a software clear written as one
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      brk_lp_r <= 1'b0;
    end else if (i_brk && lp_r == sip_pkg::SIP_WAIT) begin
      brk_lp_r <= 1'b1;
    end else if (do_wr && wb0_r && aw_addr_r == `SIP_OFS_BRK_STAT && wdat_r[`SIP_BIT_BRK_LP]) begin
      brk_lp_r <= 1'b0;
    end
  end

  // ==========================================
  // low-power sequencer
  assign wake = |i_irq_pend;

  always_comb begin
    lp_nxt = lp_r;
    unique case (lp_r)
      sip_pkg::SIP_RUN: begin
        if (i_stop_exec) begin
          lp_nxt = sip_pkg::SIP_STOP;
        end else if (i_wait_exec) begin
          lp_nxt = sip_pkg::SIP_WAIT;
        end
      end
      sip_pkg::SIP_WAIT: begin
        if (wake || (i_brk && i_emul_mode)) begin
          lp_nxt = sip_pkg::SIP_RUN;
        end
      end
      sip_pkg::SIP_STOP: begin
        if (wake || i_brk) begin
          lp_nxt = sip_pkg::SIP_RECOV;
        end
      end
      sip_pkg::SIP_RECOV: begin
        if (recov_done) begin
          lp_nxt = sip_pkg::SIP_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      lp_r <= sip_pkg::SIP_RUN;
    end else begin
      lp_r <= lp_nxt;
    end
  end

  sip_recov_ctr #(
    .LONG_CYC  (RECOV_LONG),
    .SHORT_CYC (RECOV_SHORT)
  ) u_recov (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_hold  (lp_r != sip_pkg::SIP_RECOV),
    .i_short (cfg_r[`SIP_BIT_SHORT_REC]),
    .o_done  (recov_done)
  );

  // ==========================================
  // registered processor-side outputs
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_clr_imask <= 1'b0;
      o_stack_go  <= 1'b0;
      o_wdog_en   <= 1'b1;
      o_clk_en    <= 4'hF;
    end else begin
      o_clr_imask <= lp_r == sip_pkg::SIP_RUN && (i_wait_exec || i_stop_exec);
      // wait wake answers in the cycle after the interrupt, stop after recovery
      o_stack_go  <= (lp_r == sip_pkg::SIP_WAIT && wake) ||
                     (lp_r == sip_pkg::SIP_RECOV && recov_done);
      o_wdog_en   <= !cfg_r[`SIP_BIT_WDOG_DIS];
      o_clk_en.cpu    <= lp_nxt == sip_pkg::SIP_RUN;
      o_clk_en.periph <= lp_nxt == sip_pkg::SIP_RUN || lp_nxt == sip_pkg::SIP_WAIT;
      o_clk_en.bus_clock_double <= lp_nxt != sip_pkg::SIP_STOP || cfg_r[`SIP_BIT_OSC_HALT];
      o_clk_en.bus_clock_quad   <= lp_nxt != sip_pkg::SIP_STOP;
    end
  end

endmodule

// ### bench/sip_core_props.sv
// assertion checker for the system integration block
module sip_core_props #(
  parameter int RECOV_SHORT = 32
) (
  // clock and reset
  input wire logic                  i_mclk,
  input wire logic                  i_rst,
  // processor side inputs
  input wire logic [22:1]           i_irq_pend,
  input wire logic                  i_wait_exec,
  input wire logic                  i_stop_exec,
  input wire logic                  i_brk,
  // watched outputs
  input wire sip_pkg::sip_clk_en_s  o_clk_en,
  input wire logic                  o_clr_imask,
  input wire logic                  o_swi_vec,
  input wire logic                  o_stack_go,
  input wire logic                  o_flag_clr_ok,
  input wire logic                  o_wdog_en
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // ==========================================
  // cycles with peripheral clocks gated, saturating
  logic [15:0] off_cnt_r;
  always_ff @(posedge i_mclk) begin
    if (i_rst || o_clk_en.periph) begin
      off_cnt_r <= 16'h0000;
    end else if (off_cnt_r != 16'hFFFF) begin
      off_cnt_r <= off_cnt_r + 16'h0001;
    end
  end

  // ==========================================
  // properties
  property p_swi; $rose(i_brk) |=> o_swi_vec; endproperty
  a_swi: assert property (p_swi) else $error("vector not forced after break");
  property p_prot; (!i_brk && !$past(i_brk)) |-> o_flag_clr_ok; endproperty
  a_prot: assert property (p_prot) else $error("flags blocked outside break");
  property p_imask; (i_wait_exec || i_stop_exec) && o_clk_en.cpu |=> o_clr_imask; endproperty
  a_imask: assert property (p_imask) else $error("mask not cleared on low-power entry");
  property p_wait; i_wait_exec && !i_stop_exec && o_clk_en.cpu |=> !o_clk_en.cpu && o_clk_en.periph; endproperty
  a_wait: assert property (p_wait) else $error("wait clock gating wrong");
  property p_stop; i_stop_exec && o_clk_en.cpu |=> !o_clk_en.cpu && !o_clk_en.periph && !o_clk_en.bus_clock_quad;
  endproperty
  a_stop: assert property (p_stop) else $error("stop clock gating wrong");
  property p_wake; !o_clk_en.cpu && o_clk_en.periph && (|i_irq_pend) |=> o_stack_go && o_clk_en.cpu; endproperty
  a_wake: assert property (p_wake) else $error("wait wake-up late");
  property p_recov; $rose(o_clk_en.periph) |-> off_cnt_r >= 16'(RECOV_SHORT); endproperty
  a_recov: assert property (p_recov) else $error("stop recovery too short");
  property p_rstv; $fell(i_rst) |-> o_wdog_en && o_clk_en == 4'hF && o_flag_clr_ok; endproperty
  a_rstv: assert property (p_rstv) else $error("reset levels wrong");
endmodule

bind sip_core sip_core_props #(.RECOV_SHORT(RECOV_SHORT)) u_props (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_irq_pend(i_irq_pend), .i_wait_exec(i_wait_exec),
  .i_stop_exec(i_stop_exec), .i_brk(i_brk), .o_clk_en(o_clk_en), .o_clr_imask(o_clr_imask),
  .o_swi_vec(o_swi_vec), .o_stack_go(o_stack_go), .o_flag_clr_ok(o_flag_clr_ok), .o_wdog_en(o_wdog_en));

// ### bench/sip_periph_model.sv
// peripheral model holding one status flag with a two-step clear
module sip_periph_model (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // flag events and clear permission
  input  wire logic i_set,
  input  wire logic i_step1,
  input  wire logic i_step2,
  input  wire logic i_clr_ok,
  // status flag
  output logic      o_flag
);
  logic armed_r;
  // the first step is remembered across break so that the second completes later
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_flag  <= 1'b0;
      armed_r <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_step2 && armed_r && i_clr_ok) begin
      o_flag  <= 1'b0;
      armed_r <= 1'b0;
    end else if (i_step1) begin
      armed_r <= 1'b1;
    end
  end
endmodule

// ### bench/tb_sip_core.sv
// self-checking testbench of the system integration block
`include "sip_regs.svh"
module tb_sip_core;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RLONG  = 64;
  localparam int RSHORT = 32;
  logic mclk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_r, wr_r;
  logic [22:1] irq_drv, irq_pend;
  logic wait_x, stop_x, brk, emul, pin_n, lowv, clr_imask, swi_vec, stack_go, clr_ok, wdog_en;
  logic p_set, p_s1, p_s2, kbd_flag;
  sip_pkg::sip_rst_src_s rsrc;
  sip_pkg::sip_clk_en_s  clk_en;
  int err_count, checks_done, n;
  logic [21:0] pat [3] = '{22'h3FFFFF, 22'h2AAAAA, 22'h155555};
  logic [23:0] exq [3] = '{24'hF4FFFF, 24'hA0AAAA, 24'h545555};

  // keyboard source comes from the peripheral model
  assign irq_pend = irq_drv | {8'h00, kbd_flag, 13'h0000};

  sip_core #(.RECOV_LONG(RLONG), .RECOV_SHORT(RSHORT)) i_dut (
    .i_mclk(mclk), .i_rst(rst), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_irq_pend(irq_pend),
    .i_wait_exec(wait_x), .i_stop_exec(stop_x), .i_brk(brk), .i_emul_mode(emul), .i_rst_src(rsrc),
    .i_pin_rst_n(pin_n), .i_low_volt(lowv), .o_clk_en(clk_en), .o_clr_imask(clr_imask),
    .o_swi_vec(swi_vec), .o_stack_go(stack_go), .o_flag_clr_ok(clr_ok), .o_wdog_en(wdog_en));

  sip_periph_model i_periph (
    .i_mclk(mclk), .i_rst(rst), .i_set(p_set), .i_step1(p_s1), .i_step2(p_s2), .i_clr_ok(clr_ok),
    .o_flag(kbd_flag));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ==========================================
  // checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && t < 50);
    wr_r = bresp;
    bready <= 1'b0;
    if (t >= 50) err_count++;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && t < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (t >= 50) err_count++;
    @(posedge mclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a, rd_d, rd_r);
    chk(nm, rd_d, e);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_of_test();
  end

  // ==========================================
  // test sequence
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h21;
    {awaddr, araddr, wdata, wstrb, irq_drv} = '0;
    {wait_x, stop_x, brk, emul, lowv, p_set, p_s1, p_s2} = 8'h00;
    pin_n = 1'b1;
    rsrc = '0;
    tick(16);
    rst <= 1'b0;
    rdc(`SIP_OFS_RST_SRC, 32'h80, "rst_por");
    rdc(`SIP_OFS_RST_SRC, 32'h00, "rst_rdclr");
    rsrc <= 4'hC;
    tick(1);
    rsrc <= 4'h0;
    tick(2);
    rdc(`SIP_OFS_RST_SRC, 32'h30, "rst_two");
    pin_n <= 1'b0;
    lowv <= 1'b1;
    rsrc <= 4'h3;
    tick(1);
    rsrc <= 4'h0;
    tick(2);
    pin_n <= 1'b1;
    lowv <= 1'b0;
    tick(8);
    rdc(`SIP_OFS_RST_SRC, 32'h4E, "rst_pin_lv");
    rsrc <= 4'h8;
    tick(1);
    rsrc <= 4'h0;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    rdc(`SIP_OFS_RST_SRC, 32'h80, "rst_por2");
    for (int i = 0; i < 3; i++) begin
      irq_drv <= pat[i];
      tick(2);
      rdc(`SIP_OFS_IRQ_A, {24'h0, exq[i][23:16]}, "irq_a");
      rdc(`SIP_OFS_IRQ_B, {24'h0, exq[i][15:8]}, "irq_b");
      rdc(`SIP_OFS_IRQ_C, {24'h0, exq[i][7:0]}, "irq_c");
    end
    irq_drv <= '0;
    wr(`SIP_OFS_IRQ_A, 32'hFF);
    wr(`SIP_OFS_IRQ_C, 32'hFF);
    chk("wr_ro_resp", wr_r, 32'h0);
    rdc(`SIP_OFS_IRQ_A, 32'h00, "irq_a_ro");
    rdc(`SIP_OFS_IRQ_C, 32'h00, "irq_c_ro");
    rd(8'h40, rd_d, rd_r);
    chk("unmapped", rd_r, 32'h3);
    wr(8'h40, 32'hFF);
    chk("wr_unmapped", wr_r, 32'h3);
    p_set <= 1'b1;
    tick(1);
    p_set <= 1'b0;
    p_s1 <= 1'b1;
    tick(1);
    p_s1 <= 1'b0;
    brk <= 1'b1;
    tick(1);
    @(negedge mclk);
    chk("swi_vec", swi_vec, 1);
    chk("clr_ok_brk", clr_ok, 0);
    @(posedge mclk);
    p_s2 <= 1'b1;
    tick(1);
    p_s2 <= 1'b0;
    tick(1);
    chk("flag_kept", kbd_flag, 1);
    wr(`SIP_OFS_BRK_CTL, 32'h1);
    chk("clr_ok_en", clr_ok, 1);
    rdc(`SIP_OFS_BRK_CTL, 32'h1, "brk_ctl");
    p_s2 <= 1'b1;
    tick(1);
    p_s2 <= 1'b0;
    wr(`SIP_OFS_BRK_CTL, 32'h0);
    brk <= 1'b0;
    tick(3);
    chk("flag_cleared", kbd_flag, 0);
    wr(`SIP_OFS_CFG_ONE, 32'h0);
    chk("wdog_on", wdog_en, 1);
    wait_x <= 1'b1;
    tick(1);
    wait_x <= 1'b0;
    @(negedge mclk);
    chk("wait_clk", clk_en, 4'h7);
    chk("imask", clr_imask, 1);
    @(posedge mclk);
    brk <= 1'b1;
    tick(1);
    brk <= 1'b0;
    tick(2);
    rdc(`SIP_OFS_BRK_STAT, 32'h2, "brk_lp");
    irq_drv <= 22'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!stack_go && n < 20);
    chk("wake_lat", 32'(n <= 2), 1);
    irq_drv <= '0;
    wr(`SIP_OFS_BRK_STAT, 32'h2);
    wait_x <= 1'b1;
    tick(1);
    wait_x <= 1'b0;
    emul <= 1'b1;
    brk <= 1'b1;
    tick(3);
    brk <= 1'b0;
    emul <= 1'b0;
    rdc(`SIP_OFS_LP_STAT, 32'h1, "emul_exit");
    for (int s = 0; s < 2; s++) begin
      wr(`SIP_OFS_CFG_ONE, s ? 32'h5 : 32'h2);
      chk("wdog_en", wdog_en, s ? 0 : 1);
      stop_x <= 1'b1;
      tick(1);
      stop_x <= 1'b0;
      @(negedge mclk);
      chk("stop_clk", clk_en, s ? 4'h2 : 4'h0);
      tick(5);
      // the long pass leaves stop by break, the short one by an interrupt
      if (s) brk <= 1'b1;
      else irq_drv <= 22'h4;
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (!stack_go && n < 200);
      chk("recov", 32'(n >= (s ? RLONG : RSHORT) && n <= (s ? RLONG : RSHORT) + 4), 1);
      irq_drv <= '0;
      brk <= 1'b0;
      tick(2);
      chk("clk_back", clk_en, 4'hF);
    end
    end_of_test();
  end
endmodule
